/* src/bsr_exec.sv */
// Execution of the bit, skip and return instruction group
// Function
// - clear_flag_port drives port C low in one cycle.
// - clear_pin_out_bit clears port D bit indexed by register Y.
// - Port D set/clear with Y above 3 change nothing.
// - ret_from_irq pops PC, decrements SP, restores saved context.
// - ret_skip pops PC, decrements SP, skips next instruction, two cycles.
// - set_mem_bit sets immediate-selected bit of memory word, one cycle.
// - set_pin_out_bit sets port D bit indexed by register Y.
// - skip_acc_eq_imm, two words, skips when accumulator equals immediate.
// - skip_acc_eq_mem skips when accumulator equals memory word.
// - ext0_skip skips and clears ext0 flag when enabled, else no-op.
// - conv_done_skip skips and clears conversion flag when enabled, else no-op.
// - flag_port_skip skips when port C holds one.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module bsr_exec #(
  parameter int SP_W = 3,
  parameter int PC_W = 12
) (
  input wire logic sys_clk, // 40 MHz core clock
  input wire logic reset, // Async reset, active high
  input wire logic instr_valid, // One-cycle strobe: new instruction word
  input wire bsr_pkg::bsr_op_t instr_op, // Decoded operation
  input wire logic instr_flag_port_skip, // Word is flag_port_skip
  input wire logic instr_two_word, // Word begins a two-word instruction
  input wire logic [1:0] instr_bit, // Immediate bit select
  input wire logic [3:0] instr_imm, // Second word immediate n
  input wire bsr_pkg::bsr_dp_t dp_in, // Current data pointer
  input wire logic [3:0] acc_in, // Accumulator
  input wire logic [3:0] mem_rdata, // Memory word at data pointer
  input wire logic [PC_W-1:0] stack_top, // Stack entry at SP
  input wire bsr_pkg::bsr_ctx_t saved_ctx, // Context saved at interrupt
  input wire logic [7:0] irq_ctl_first, // Interrupt control register 1
  input wire logic [7:0] irq_ctl_second, // Interrupt control register 2
  input wire logic ext0_req_set, // Ext0 request event
  input wire logic conv_done_set, // Conversion done event
  output logic mem_we, // Memory write strobe
  output logic [3:0] mem_wdata, // Memory write data
  output logic pc_load, // PC load strobe
  output logic [PC_W-1:0] pc_value, // PC load value
  output logic sp_dec, // Stack pointer decrement strobe
  output logic ctx_restore, // Restore context strobe
  output bsr_pkg::bsr_ctx_t ctx_out, // Context to restore
  output logic carry_flag, // Carry flag
  output logic port_c, // Output port C
  output logic [3:0] port_d, // Output port D
  output logic ext0_req_flag, // External 0 request flag
  output logic conv_done_flag, // Conversion done flag
  output logic skip_next, // Next instruction is being skipped
  output logic busy // Waiting for the second word of skip_acc_eq_imm
);
  import bsr_pkg::*;

  bsr_state_t state_reg, state_next;
  logic two_word_skip_reg, two_word_skip_next;
  logic mem_we_reg, mem_we_next;
  logic [3:0] mem_wdata_reg, mem_wdata_next;
  logic pc_load_reg, pc_load_next;
  logic [PC_W-1:0] pc_value_reg, pc_value_next;
  logic sp_dec_reg, sp_dec_next;
  logic ctx_restore_reg, ctx_restore_next;
  bsr_ctx_t ctx_reg, ctx_next;
  logic carry_reg, carry_next;
  logic port_c_reg, port_c_next;
  logic [3:0] port_d_reg, port_d_next;
  logic ext0_reg, ext0_next;
  logic conv_reg, conv_next;
  logic skip_reg, skip_next_v;
  logic busy_reg, busy_next;
  logic y_ok;
  logic exec;

  function automatic logic [3:0] bit_mask(input logic [1:0] sel);
    bit_mask = 4'h1 << sel;
  endfunction : bit_mask

  // Only Y of 0..3 addresses port D
  assign y_ok = (dp_in.y < 4'(PORT_D_BITS));
  // Words are dropped while skipping or waiting for a second word
  assign exec = instr_valid && (state_reg == ST_IDLE);

  always_comb begin
    state_next = state_reg;
    two_word_skip_next = two_word_skip_reg;
    mem_we_next = 1'b0;
    mem_wdata_next = mem_rdata;
    pc_load_next = 1'b0;
    pc_value_next = pc_value_reg;
    sp_dec_next = 1'b0;
    ctx_restore_next = 1'b0;
    ctx_next = ctx_reg;
    carry_next = carry_reg;
    port_c_next = port_c_reg;
    port_d_next = port_d_reg;
    ext0_next = ext0_reg;
    conv_next = conv_reg;
    skip_next_v = 1'b0;
    case (state_reg)
      ST_SKIP: begin
        if (instr_valid) begin
          if (instr_two_word && !two_word_skip_reg) begin
            two_word_skip_next = 1'b1;
          end else begin
            two_word_skip_next = 1'b0;
            state_next = ST_IDLE;
          end
        end
        skip_next_v = 1'b1;
      end
      ST_SECOND: begin
        if (instr_valid) begin
          if (acc_in == instr_imm) begin
            state_next = ST_SKIP;
            skip_next_v = 1'b1;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (exec && instr_flag_port_skip == FLAG_PORT_SKIP_SEL) begin
          if (port_c_reg) begin
            state_next = ST_SKIP;
            skip_next_v = 1'b1;
          end
        end else if (exec) begin
          case (instr_op)
            OP_CLR_MEM_BIT: begin
              mem_we_next = 1'b1;
              mem_wdata_next = mem_rdata & ~bit_mask(instr_bit);
            end
            OP_SET_MEM_BIT: begin
              mem_we_next = 1'b1;
              mem_wdata_next = mem_rdata | bit_mask(instr_bit);
            end
            OP_CLR_CARRY: carry_next = 1'b0;
            OP_SET_CARRY: carry_next = 1'b1;
            OP_CLR_FLAG_PORT: port_c_next = 1'b0;
            OP_SET_FLAG_PORT: port_c_next = 1'b1;
            OP_CLR_PIN_OUT_BIT: begin
              if (y_ok) begin
                port_d_next = port_d_reg & ~bit_mask(dp_in.y[1:0]);
              end
            end
            OP_SET_PIN_OUT_BIT: begin
              if (y_ok) begin
                port_d_next = port_d_reg | bit_mask(dp_in.y[1:0]);
              end
            end
            OP_RET: begin
              pc_load_next = 1'b1;
              pc_value_next = stack_top;
              sp_dec_next = 1'b1;
            end
            OP_RET_SKIP: begin
              pc_load_next = 1'b1;
              pc_value_next = stack_top;
              sp_dec_next = 1'b1;
              state_next = ST_SKIP;
              skip_next_v = 1'b1;
            end
            OP_RET_FROM_IRQ: begin
              pc_load_next = 1'b1;
              pc_value_next = stack_top;
              sp_dec_next = 1'b1;
              ctx_restore_next = 1'b1;
              ctx_next = saved_ctx;
              carry_next = saved_ctx.carry;
            end
            OP_SKIP_ACC_EQ_IMM: state_next = ST_SECOND;
            OP_SKIP_ACC_EQ_MEM: begin
              if (acc_in == mem_rdata) begin
                state_next = ST_SKIP;
                skip_next_v = 1'b1;
              end
            end
            OP_EXT0_SKIP: begin
              if (!irq_ctl_first[IRQ1_EXT0_BIT] && ext0_reg) begin
                ext0_next = 1'b0;
                state_next = ST_SKIP;
                skip_next_v = 1'b1;
              end
            end
            OP_CONV_DONE_SKIP: begin
              if (!irq_ctl_second[IRQ2_CONV_BIT] && conv_reg) begin
                conv_next = 1'b0;
                state_next = ST_SKIP;
                skip_next_v = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Registered so that busy leaves a flip-flop like every other output
    busy_next = (state_next == ST_SECOND);
    // Set wins over a clearing skip in the same cycle
    if (ext0_req_set) begin
      ext0_next = 1'b1;
    end
    if (conv_done_set) begin
      conv_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      two_word_skip_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= 4'h0;
      pc_load_reg <= 1'b0;
      pc_value_reg <= '0;
      sp_dec_reg <= 1'b0;
      ctx_restore_reg <= 1'b0;
      ctx_reg <= '0;
      carry_reg <= CARRY_RESET;
      port_c_reg <= PORT_C_RESET;
      port_d_reg <= PORT_D_RESET;
      ext0_reg <= 1'b0;
      conv_reg <= 1'b0;
      skip_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      two_word_skip_reg <= two_word_skip_next;
      mem_we_reg <= mem_we_next;
      mem_wdata_reg <= mem_wdata_next;
      pc_load_reg <= pc_load_next;
      pc_value_reg <= pc_value_next;
      sp_dec_reg <= sp_dec_next;
      ctx_restore_reg <= ctx_restore_next;
      ctx_reg <= ctx_next;
      carry_reg <= carry_next;
      port_c_reg <= port_c_next;
      port_d_reg <= port_d_next;
      ext0_reg <= ext0_next;
      conv_reg <= conv_next;
      skip_reg <= skip_next_v;
      busy_reg <= busy_next;
    end
  end

  assign mem_we = mem_we_reg;
  assign mem_wdata = mem_wdata_reg;
  assign pc_load = pc_load_reg;
  assign pc_value = pc_value_reg;
  assign sp_dec = sp_dec_reg;
  assign ctx_restore = ctx_restore_reg;
  assign ctx_out = ctx_reg;
  assign carry_flag = carry_reg;
  assign port_c = port_c_reg;
  assign port_d = port_d_reg;
  assign ext0_req_flag = ext0_reg;
  assign conv_done_flag = conv_reg;
  assign skip_next = skip_reg;
  assign busy = busy_reg;

  sequence s_ret_issue;
    exec && !instr_flag_port_skip && instr_op == OP_RET_SKIP;
  endsequence

  a_clr_mem_bit: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_CLR_MEM_BIT |=> mem_we
      && mem_wdata == ($past(mem_rdata) & ~bit_mask($past(instr_bit))))
    else $error("clear_mem_bit write wrong");
  a_set_mem_bit: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_SET_MEM_BIT |=> mem_we
      && mem_wdata == ($past(mem_rdata) | bit_mask($past(instr_bit))))
    else $error("set_mem_bit write wrong");
  a_carry_clear: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_CLR_CARRY |=> !carry_flag
      && !skip_next)
    else $error("carry not cleared");
  a_carry_set: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_SET_CARRY |=> carry_flag)
    else $error("carry not set");
  a_port_c_clear: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_CLR_FLAG_PORT |=> !port_c)
    else $error("port C not cleared");
  a_port_d_guard: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && !y_ok && (instr_op == OP_SET_PIN_OUT_BIT
      || instr_op == OP_CLR_PIN_OUT_BIT) |=> $stable(port_d))
    else $error("port D changed for bad Y");
  a_port_d_clear: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && y_ok && instr_op == OP_CLR_PIN_OUT_BIT
      |=> !port_d[$past(dp_in.y[1:0])])
    else $error("port D bit not cleared");
  a_port_d_set: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && y_ok && instr_op == OP_SET_PIN_OUT_BIT
      |=> port_d[$past(dp_in.y[1:0])])
    else $error("port D bit not set");
  a_ret_skip: assert property (@(posedge sys_clk) disable iff (reset)
    s_ret_issue |=> pc_load && sp_dec && skip_next && state_reg == ST_SKIP)
    else $error("ret_skip incomplete");
  a_irq_restore: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_RET_FROM_IRQ |=> ctx_restore
      && sp_dec && ctx_out == $past(saved_ctx))
    else $error("irq return restore wrong");
  a_imm_compare: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == ST_SECOND && instr_valid |=>
      (state_reg == ST_SKIP) == ($past(acc_in) == $past(instr_imm)))
    else $error("immediate compare wrong");
  a_mem_compare: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_SKIP_ACC_EQ_MEM |=>
      skip_next == ($past(acc_in) == $past(mem_rdata)))
    else $error("memory compare wrong");
  a_ext0_masked: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_EXT0_SKIP
      && irq_ctl_first[IRQ1_EXT0_BIT] |=> !skip_next)
    else $error("ext0_skip not a no-op");
  a_conv_clear: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_CONV_DONE_SKIP && conv_reg
      && !irq_ctl_second[IRQ2_CONV_BIT] && !conv_done_set |=> skip_next && !conv_done_flag)
    else $error("conv_done_skip wrong");
  a_port_c_skip: assert property (@(posedge sys_clk) disable iff (reset)
    exec && instr_flag_port_skip |=> skip_next == $past(port_c) && $stable(port_c))
    else $error("flag_port_skip wrong");
  a_skip_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == ST_SKIP |=> !mem_we && !pc_load && $stable(port_d)
      && $stable(carry_flag) && $stable(port_c))
    else $error("skipped instruction acted");

  sequence s_two_word_first;
    state_reg == ST_SKIP && instr_valid && instr_two_word && !two_word_skip_reg;
  endsequence

  a_two_word_skip: assert property (@(posedge sys_clk) disable iff (reset)
    s_two_word_first |=> state_reg == ST_SKIP && skip_next)
    else $error("two-word skip ended early");
  a_ext0_clear: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_EXT0_SKIP && ext0_reg
      && !irq_ctl_first[IRQ1_EXT0_BIT] && !ext0_req_set |=> skip_next && !ext0_req_flag)
    else $error("ext0_skip wrong");
  a_conv_masked: assert property (@(posedge sys_clk) disable iff (reset)
    exec && !instr_flag_port_skip && instr_op == OP_CONV_DONE_SKIP
      && irq_ctl_second[IRQ2_CONV_BIT] && !conv_done_set |=> !skip_next && $stable(conv_done_flag))
    else $error("conv_done_skip not a no-op");
endmodule : bsr_exec

/* src/bsr_pkg.sv */
// Package for the bit, skip and return execution block
package bsr_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_CLR_MEM_BIT = 4'h1,
    OP_CLR_CARRY = 4'h2,
    OP_CLR_FLAG_PORT = 4'h3,
    OP_CLR_PIN_OUT_BIT = 4'h4,
    OP_RET = 4'h5,
    OP_RET_FROM_IRQ = 4'h6,
    OP_RET_SKIP = 4'h7,
    OP_SET_MEM_BIT = 4'h8,
    OP_SET_CARRY = 4'h9,
    OP_SET_FLAG_PORT = 4'hA,
    OP_SET_PIN_OUT_BIT = 4'hB,
    OP_SKIP_ACC_EQ_IMM = 4'hC,
    OP_SKIP_ACC_EQ_MEM = 4'hD,
    OP_EXT0_SKIP = 4'hE,
    OP_CONV_DONE_SKIP = 4'hF
  } bsr_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SECOND = 2'b01,
    ST_SKIP = 2'b10
  } bsr_state_t;

  typedef struct packed {
    logic [5:0] x;
    logic [3:0] y;
    logic [1:0] z;
  } bsr_dp_t;

  typedef struct packed {
    bsr_dp_t dp;
    logic carry;
    logic skip;
    logic nop_mode;
    logic [3:0] acc;
    logic [3:0] b;
  } bsr_ctx_t;

  // Separate op for flag_port_skip, outside the 4-bit enum
  localparam logic FLAG_PORT_SKIP_SEL = 1'b1;
  localparam int IRQ1_EXT0_BIT = 0;
  localparam int IRQ2_CONV_BIT = 2;
  localparam int PORT_D_BITS = 4;
  localparam logic PORT_C_RESET = 1'b0;
  localparam logic [3:0] PORT_D_RESET = 4'h0;
  localparam logic CARRY_RESET = 1'b0;
  localparam int RET_CYCLES = 2;
  localparam int SKIP_IMM_CYCLES = 2;
endpackage : bsr_pkg

/* tb/test_bsr_exec.sv */
// Self-checking bench for the bit, skip and return execution block
`timescale 1ns/1ps
module test_bsr_exec;
  import bsr_pkg::*;
  logic sys_clk, reset, instr_valid, instr_flag_port_skip, instr_two_word;
  bsr_op_t instr_op;
  logic [1:0] instr_bit;
  logic [3:0] instr_imm, acc_in, mem_rdata, mem_wdata, port_d, exp_d;
  bsr_dp_t dp_in;
  logic [11:0] stack_top, pc_value;
  bsr_ctx_t saved_ctx, ctx_out;
  logic [7:0] irq_ctl_first, irq_ctl_second;
  logic ext0_req_set, conv_done_set, mem_we, pc_load, sp_dec, ctx_restore, carry_flag;
  logic port_c, ext0_req_flag, conv_done_flag, skip_next, busy;
  int errors, cmp_count;

  bsr_exec #(.SP_W(3), .PC_W(12)) DUT (
    .sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_flag_port_skip(instr_flag_port_skip), .instr_two_word(instr_two_word),
    .instr_bit(instr_bit), .instr_imm(instr_imm), .dp_in(dp_in), .acc_in(acc_in),
    .mem_rdata(mem_rdata), .stack_top(stack_top), .saved_ctx(saved_ctx),
    .irq_ctl_first(irq_ctl_first), .irq_ctl_second(irq_ctl_second),
    .ext0_req_set(ext0_req_set), .conv_done_set(conv_done_set), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .pc_load(pc_load), .pc_value(pc_value), .sp_dec(sp_dec),
    .ctx_restore(ctx_restore), .ctx_out(ctx_out), .carry_flag(carry_flag),
    .port_c(port_c), .port_d(port_d), .ext0_req_flag(ext0_req_flag),
    .conv_done_flag(conv_done_flag), .skip_next(skip_next), .busy(busy)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic give_verdict;
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // One instruction word; returns once the taking edge's updates have landed
  task automatic issue(input bsr_op_t op, input logic [1:0] b = 2'b00,
                       input logic [3:0] imm = 4'h0, input logic two = 1'b0,
                       input logic fps = 1'b0);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_bit <= b;
    instr_imm <= imm;
    instr_two_word <= two;
    instr_flag_port_skip <= fps;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    instr_two_word <= 1'b0;
    instr_flag_port_skip <= 1'b0;
    #1;
  endtask : issue

  task automatic pulse_evt(input int s);
    @(posedge sys_clk);
    ext0_req_set <= (s == 0);
    conv_done_set <= (s == 1);
    @(posedge sys_clk);
    ext0_req_set <= 1'b0;
    conv_done_set <= 1'b0;
    #1;
  endtask : pulse_evt

  function automatic logic flg(input int s);
    return (s == 0) ? ext0_req_flag : conv_done_flag;
  endfunction : flg

  // Generous bound: the sequence needs well under a thousand cycles
  initial begin
    #(25 * 3000);
    errors++;
    give_verdict();
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    reset = 1'b1;
    {instr_valid, instr_flag_port_skip, instr_two_word, instr_bit, instr_imm} = '0;
    instr_op = OP_NOP;
    {dp_in, acc_in, mem_rdata, stack_top, saved_ctx} = '0;
    {irq_ctl_first, irq_ctl_second, ext0_req_set, conv_done_set} = '0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk("reset_outs", 0, {carry_flag, port_c, port_d, ext0_req_flag, conv_done_flag,
        skip_next, busy, mem_we, pc_load, sp_dec, ctx_restore});
    for (int j = 0; j < 4; j++) begin
      mem_rdata <= 4'hF;
      issue(OP_CLR_MEM_BIT, 2'(j));
      chk("clr_mem", {1'b1, 4'hF & ~(4'h1 << j)}, {mem_we, mem_wdata});
      mem_rdata <= 4'h0;
      issue(OP_SET_MEM_BIT, 2'(j));
      chk("set_mem", {1'b1, 4'h1 << j}, {mem_we, mem_wdata});
    end
    issue(OP_SET_CARRY);
    chk("carry_set", 1, carry_flag);
    issue(OP_CLR_CARRY);
    chk("carry_clr", 2'b00, {carry_flag, skip_next});
    exp_d = 4'h0;
    for (int y = 5; y >= 0; y--) begin
      dp_in.y <= 4'(y);
      issue(OP_SET_PIN_OUT_BIT);
      if (y < 4) exp_d[y] = 1'b1;
      chk("port_d_set", exp_d, port_d);
    end
    for (int y = 5; y >= 0; y--) begin
      dp_in.y <= 4'(y);
      issue(OP_CLR_PIN_OUT_BIT);
      if (y < 4) exp_d[y] = 1'b0;
      chk("port_d_clr", exp_d, port_d);
    end
    acc_in <= 4'h6;
    mem_rdata <= 4'h6;
    issue(OP_SKIP_ACC_EQ_MEM);
    chk("skip_acc_eq_mem_eq", 1, skip_next);
    issue(OP_SET_CARRY);
    chk("skipped_carry", 0, carry_flag);
    mem_rdata <= 4'h7;
    issue(OP_SKIP_ACC_EQ_MEM);
    chk("skip_acc_eq_mem_ne", 0, skip_next);
    issue(OP_SET_CARRY);
    chk("run_carry", 1, carry_flag);
    for (int k = 0; k < 3; k++) begin
      acc_in <= (k == 2) ? 4'hF : 4'h6;
      issue(OP_SKIP_ACC_EQ_IMM);
      chk("imm_busy", 1, busy);
      issue(OP_NOP, 2'b00, (k == 0) ? 4'h6 : ((k == 1) ? 4'h7 : 4'hF));
      chk("imm_skip", (k != 1), skip_next);
      if (k != 1) begin
        issue(OP_SKIP_ACC_EQ_IMM, 2'b00, 4'h0, 1'b1);
        issue(OP_CLR_CARRY);
        // skip_next still shows the skip in the cycle after the last dropped word
        chk("two_word_skip", 2'b11, {carry_flag, skip_next});
      end
    end
    issue(OP_NOP, 2'b00, 4'h0, 1'b0, 1'b1);
    chk("fps_low", 0, skip_next);
    issue(OP_SET_FLAG_PORT);
    issue(OP_NOP, 2'b00, 4'h0, 1'b0, 1'b1);
    chk("fps_high", 2'b11, {skip_next, port_c});
    issue(OP_CLR_FLAG_PORT);
    chk("fps_skipped", 1, port_c);
    issue(OP_CLR_FLAG_PORT);
    chk("port_c_clr", 0, port_c);
    for (int s = 0; s < 2; s++) begin
      pulse_evt(s);
      chk("req_flag_set", 1, flg(s));
      irq_ctl_first[IRQ1_EXT0_BIT] <= (s == 0);
      irq_ctl_second[IRQ2_CONV_BIT] <= (s == 1);
      issue((s == 0) ? OP_EXT0_SKIP : OP_CONV_DONE_SKIP);
      chk("req_nop", 2'b01, {skip_next, flg(s)});
      irq_ctl_first <= 8'h00;
      irq_ctl_second <= 8'h00;
      issue((s == 0) ? OP_EXT0_SKIP : OP_CONV_DONE_SKIP);
      chk("req_skip", 2'b10, {skip_next, flg(s)});
      issue(OP_NOP);
      issue((s == 0) ? OP_EXT0_SKIP : OP_CONV_DONE_SKIP);
      chk("req_zero", 2'b00, {skip_next, flg(s)});
    end
    issue(OP_CLR_CARRY);
    stack_top <= 12'hA5C;
    saved_ctx <= '{dp: '{x: 6'h2A, y: 4'h9, z: 2'h3}, carry: 1'b1, skip: 1'b1,
                   nop_mode: 1'b0, acc: 4'hC, b: 4'h3};
    issue(OP_RET_FROM_IRQ);
    chk("rti_strobes", 5'b11111, {pc_load, sp_dec, ctx_restore, carry_flag, ~skip_next});
    chk("rti_pc", 12'hA5C, pc_value);
    chk("rti_ctx", saved_ctx, ctx_out);
    stack_top <= 12'h123;
    issue(OP_RET_SKIP);
    chk("rts_strobes", 3'b111, {pc_load, sp_dec, skip_next});
    chk("rts_pc", 12'h123, pc_value);
    issue(OP_CLR_CARRY);
    chk("rts_skipped", 2'b11, {carry_flag, skip_next});
    // Plain return pops like ret_skip but must not skip
    stack_top <= 12'h3C0;
    issue(OP_RET);
    chk("ret_strobes", 4'b1100, {pc_load, sp_dec, skip_next, ctx_restore});
    chk("ret_pc", 12'h3C0, pc_value);
    give_verdict();
  end
endmodule : test_bsr_exec
